// ==== verilog/psram_strobe_pkg.sv ====
// Shared constants and carrier types for the memory-side strobe bus slave
package psram_strobe_pkg;

	// System clock rate and timing figures
	localparam int CLOCK_PERIOD_NS         = 40;
	localparam int REFRESH_PERIOD_NS       = 4000;
	localparam int SELECT_LOW_LIMIT_IND_NS = 4000;
	localparam int SELECT_LOW_LIMIT_EXT_NS = 1000;

	localparam logic [7:0] REFRESH_LAST   = 8'(REFRESH_PERIOD_NS / CLOCK_PERIOD_NS - 1);
	localparam logic [7:0] SEL_LIMIT_IND  = 8'(SELECT_LOW_LIMIT_IND_NS / CLOCK_PERIOD_NS);
	localparam logic [7:0] SEL_LIMIT_EXT  = 8'(SELECT_LOW_LIMIT_EXT_NS / CLOCK_PERIOD_NS);

	// Link framing
	localparam logic [1:0] CA_LAST_PAIR   = 2'h2;
	localparam logic [3:0] LAT_CLKS       = 4'h4;
	localparam logic [3:0] LAT_BASE_LOAD  = LAT_CLKS - 4'h1;
	localparam logic [3:0] LAT_EXTRA_LOAD = LAT_CLKS + LAT_CLKS - 4'h1;
	localparam int         MEM_WORDS      = 128;

	// Reset values
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam logic [7:0]  TIMER_RESET   = 8'h00;
	localparam logic [6:0]  ADDR_RESET    = 7'h00;

	// Command-address word, first byte in the top bits
	typedef struct packed {
		logic        is_read;
		logic        space;
		logic        burst;
		logic [28:0] upper;
		logic [12:0] rsvd;
		logic [2:0]  lower;
	} ca_t;

	// One clock of data: rising-edge byte then falling-edge byte
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} pair_t;

	typedef enum logic [3:0] {
		S_CMD = 4'h1,
		S_LAT = 4'h2,
		S_RD  = 4'h4,
		S_WR  = 4'h8
	} link_state_t;

endpackage : psram_strobe_pkg

// ==== verilog/psram_strobe_slave.sv ====
// Memory-side double-data-rate strobe bus slave with small array
// Function
// R1: Chip select falling edge starts a new command.
// R2: Chip select rising edge abandons the current access.
// R3: Bytes are captured and driven at the clock crossing.
// R4: On the 3 V variant the complement clock is ignored.
// R5: With centre strobe option, strobe edges follow the shifted clock.
// R6: Master supplies shifted clock as bus clock delayed 90 degrees.
// R7: Master may pick another phase offset for its margins.
// R8: Shifted clock is unused during writes; master parks it low.
// R9: Shifted clock is differential on 1.8 V parts only.
// R10: Read strobe transitions come from shifted clock; data aligns to them. Here data changes on the bus clock crossing instead.
// R11: During writes the strobe is a master-driven byte mask.
// R12: Strobe at transaction start flags extra initial latency, 1 means extra.
// R13: Hardware reset low returns the device to idle.
// R14: Hardware reset low floats strobe and all data lines.
// R15: Master keeps chip select low no longer than the limit.
// R16: Command-address and data share eight lines, direction by phase.
// R17: Master starts with clock low and raises select between transactions.
// R18: Master sets the shifted clock delay, 40 to 140 degrees.
// R19: Bytes move on both clock edges, two per cycle.
// R20: Write byte is stored when strobe low, skipped when high.
module psram_strobe_slave #(
	parameter bit THREE_VOLT_PART = 1'b0,
	parameter bit CENTER_STROBE   = 1'b1,
	parameter bit INDUSTRIAL_PLUS = 1'b0
) (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        hw_reset_b,
	input  wire logic        chip_select_b,
	input  wire logic        bus_clock,
	input  wire logic        clock_complement,
	input  wire logic        shifted_clock,
	input  wire logic        shifted_clock_complement,
	input  wire logic [7:0]  dq_in,
	output logic      [7:0]  dq_out,
	output logic             dq_oe_b,
	input  wire logic        read_write_strobe_in,
	output logic             read_write_strobe_out,
	output logic             read_write_strobe_oe_b,
	output logic      [15:0] transaction_count,
	output logic             last_was_read,
	output logic             refresh_pending,
	output logic             select_low_exceeded
);

	// Clock crossings of the incoming pairs
	logic ck_x;
	logic psc_x;

	assign ck_x  = THREE_VOLT_PART ? bus_clock : (bus_clock & ~clock_complement); // R3 R4
	assign psc_x = THREE_VOLT_PART ? shifted_clock : (shifted_clock & ~shifted_clock_complement); // R9

	// System domain state
	logic        hw_meta_r;
	logic        hw_ok_r;
	logic        cs_meta_r;
	logic        cs_sync_r;
	logic        tg_meta_r;
	logic        tg_sync_r;
	logic        tg_last_r;
	logic        cmd_pulse;
	logic [15:0] count_r,     count_nxt;
	logic        last_read_r, last_read_nxt;
	logic [7:0]  ref_cnt_r,   ref_cnt_nxt;
	logic        ref_due_r,   ref_due_nxt;
	logic [7:0]  sel_cnt_r,   sel_cnt_nxt;
	logic        sel_over_r,  sel_over_nxt;
	logic        ref_tick;

	// Link domain state
	logic                          link_arst_b;
	logic                          link_keep_b;
	psram_strobe_pkg::link_state_t st_r,     st_nxt;
	logic [1:0]                    ca_cnt_r, ca_cnt_nxt;
	psram_strobe_pkg::ca_t         ca_r,     ca_nxt;
	logic [3:0]                    lat_r,    lat_nxt;
	logic [6:0]                    addr_r,   addr_nxt;
	logic                          extra_r,  extra_nxt;
	logic                          is_rd_r,  is_rd_nxt;
	psram_strobe_pkg::pair_t       rd_r,     rd_nxt;
	logic [7:0]                    first_r,  first_nxt;
	logic [7:0]                    lo_r,     lo_nxt;
	logic                          fmask_r,  fmask_nxt;
	logic                          ref_meta_r;
	logic                          ref_sync_r, ref_sync_nxt;
	logic                          tgl_r,    tgl_nxt;
	logic                          cmd_rd_r, cmd_rd_nxt;
	logic                          cmd_ex_r, cmd_ex_nxt;
	logic                          we_hi;
	logic                          we_lo;
	psram_strobe_pkg::pair_t       mem [0:psram_strobe_pkg::MEM_WORDS-1];

	// Pin and link-level synchronisers into the system clock
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hw_meta_r <= 1'b0;
			hw_ok_r   <= 1'b0;
			cs_meta_r <= 1'b1;
			cs_sync_r <= 1'b1;
			tg_meta_r <= 1'b0;
			tg_sync_r <= 1'b0;
			tg_last_r <= 1'b0;
		end else begin
			hw_meta_r <= hw_reset_b;
			hw_ok_r   <= hw_meta_r;
			cs_meta_r <= chip_select_b;
			cs_sync_r <= cs_meta_r;
			tg_meta_r <= tgl_r;
			tg_sync_r <= tg_meta_r;
			tg_last_r <= tg_sync_r;
		end
	end

	assign cmd_pulse = tg_sync_r ^ tg_last_r;
	assign ref_tick  = (ref_cnt_r == psram_strobe_pkg::REFRESH_LAST);

	always_comb begin
		count_nxt     = count_r;
		last_read_nxt = last_read_r;
		ref_cnt_nxt   = ref_tick ? psram_strobe_pkg::TIMER_RESET : ref_cnt_r + 8'h01;
		ref_due_nxt   = ref_due_r;
		sel_cnt_nxt   = sel_cnt_r;
		sel_over_nxt  = 1'b0;
		if (cmd_pulse) begin
			count_nxt     = count_r + 16'h0001;
			last_read_nxt = cmd_rd_r;
			if (cmd_ex_r)
				ref_due_nxt = 1'b0;
		end
		// New refresh request wins over the clear
		if (ref_tick)
			ref_due_nxt = 1'b1;
		if (cs_sync_r) begin
			sel_cnt_nxt = psram_strobe_pkg::TIMER_RESET;
		end else begin
			if (sel_cnt_r != 8'hFF)
				sel_cnt_nxt = sel_cnt_r + 8'h01;
			sel_over_nxt = sel_cnt_r >= (INDUSTRIAL_PLUS ? psram_strobe_pkg::SEL_LIMIT_EXT
				: psram_strobe_pkg::SEL_LIMIT_IND);
		end
		// Hardware reset pin holds everything at idle
		if (!hw_ok_r) begin // R13
			count_nxt     = psram_strobe_pkg::COUNT_RESET;
			last_read_nxt = 1'b0;
			ref_cnt_nxt   = psram_strobe_pkg::TIMER_RESET;
			ref_due_nxt   = 1'b0;
			sel_cnt_nxt   = psram_strobe_pkg::TIMER_RESET;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			count_r     <= psram_strobe_pkg::COUNT_RESET;
			last_read_r <= 1'b0;
			ref_cnt_r   <= psram_strobe_pkg::TIMER_RESET;
			ref_due_r   <= 1'b0;
			sel_cnt_r   <= psram_strobe_pkg::TIMER_RESET;
			sel_over_r  <= 1'b0;
		end else begin
			count_r     <= count_nxt;
			last_read_r <= last_read_nxt;
			ref_cnt_r   <= ref_cnt_nxt;
			ref_due_r   <= ref_due_nxt;
			sel_cnt_r   <= sel_cnt_nxt;
			sel_over_r  <= sel_over_nxt;
		end
	end

	assign transaction_count   = count_r;
	assign last_was_read       = last_read_r;
	assign refresh_pending     = ref_due_r;
	assign select_low_exceeded = sel_over_r;

	// Frame logic is cleared whenever select is high or the device is in reset
	assign link_arst_b = ~chip_select_b & hw_ok_r & rst_b; // R1 R2 R13
	assign link_keep_b = hw_ok_r & rst_b;

	// Rising-edge byte and its mask
	assign first_nxt = dq_in;
	assign fmask_nxt = read_write_strobe_in;

	always_ff @(posedge ck_x or negedge link_arst_b) begin
		if (!link_arst_b) begin
			first_r <= 8'h00;
			fmask_r <= 1'b1;
		end else begin
			first_r <= first_nxt; // R19
			fmask_r <= fmask_nxt;
		end
	end

	// Frame sequencer on the falling edge, one byte pair per clock
	always_comb begin
		psram_strobe_pkg::ca_t ca_new;
		ca_new     = psram_strobe_pkg::ca_t'({ca_r[31:0], first_r, dq_in});
		st_nxt     = st_r;
		ca_cnt_nxt = ca_cnt_r;
		ca_nxt     = ca_r;
		lat_nxt    = lat_r;
		addr_nxt   = addr_r;
		extra_nxt  = extra_r;
		is_rd_nxt  = is_rd_r;
		rd_nxt     = rd_r;
		tgl_nxt    = tgl_r;
		cmd_rd_nxt = cmd_rd_r;
		cmd_ex_nxt = cmd_ex_r;
		we_hi      = 1'b0;
		we_lo      = 1'b0;
		lo_nxt     = rd_r.lo;
		ref_sync_nxt = (st_r == psram_strobe_pkg::S_CMD) ? ref_sync_r : ref_meta_r; // R12
		case (st_r)
			psram_strobe_pkg::S_CMD: begin
				ca_nxt     = ca_new; // R16 R19
				ca_cnt_nxt = ca_cnt_r + 2'h1;
				if (ca_cnt_r == psram_strobe_pkg::CA_LAST_PAIR) begin
					st_nxt     = psram_strobe_pkg::S_LAT;
					extra_nxt  = ref_sync_r; // R12
					lat_nxt    = ref_sync_r ? psram_strobe_pkg::LAT_EXTRA_LOAD : psram_strobe_pkg::LAT_BASE_LOAD;
					addr_nxt   = {ca_new.upper[3:0], ca_new.lower};
					is_rd_nxt  = ca_new.is_read;
					tgl_nxt    = ~tgl_r;
					cmd_rd_nxt = ca_new.is_read;
					cmd_ex_nxt = ref_sync_r;
				end
			end
			psram_strobe_pkg::S_LAT: begin
				lat_nxt = lat_r - 4'h1;
				if (lat_r == 4'h0) begin
					st_nxt = is_rd_r ? psram_strobe_pkg::S_RD : psram_strobe_pkg::S_WR; // R16
					if (is_rd_r) begin
						rd_nxt   = mem[addr_r];
						addr_nxt = addr_r + 7'h01;
					end
				end
			end
			psram_strobe_pkg::S_RD: begin
				rd_nxt   = mem[addr_r];
				addr_nxt = addr_r + 7'h01;
			end
			psram_strobe_pkg::S_WR: begin
				we_hi    = ~fmask_r; // R20
				we_lo    = ~read_write_strobe_in; // R11 R20
				addr_nxt = addr_r + 7'h01;
			end
			default: st_nxt = psram_strobe_pkg::S_CMD;
		endcase
	end

	always_ff @(negedge ck_x or negedge link_arst_b) begin
		if (!link_arst_b) begin
			st_r     <= psram_strobe_pkg::S_CMD; // R1 R2
			ca_cnt_r <= 2'h0;
			ca_r     <= '0;
			lat_r    <= 4'h0;
			addr_r   <= psram_strobe_pkg::ADDR_RESET;
			extra_r  <= 1'b0;
			is_rd_r  <= 1'b0;
			rd_r     <= '0;
			lo_r     <= 8'h00;
		end else begin
			st_r     <= st_nxt;
			ca_cnt_r <= ca_cnt_nxt;
			ca_r     <= ca_nxt;
			lat_r    <= lat_nxt;
			addr_r   <= addr_nxt;
			extra_r  <= extra_nxt;
			is_rd_r  <= is_rd_nxt;
			rd_r     <= rd_nxt;
			lo_r     <= lo_nxt;
		end
	end

	// State that outlives a frame
	always_ff @(negedge ck_x or negedge link_keep_b) begin
		if (!link_keep_b) begin
			ref_meta_r <= 1'b0;
			ref_sync_r <= 1'b0;
			tgl_r      <= 1'b0;
			cmd_rd_r   <= 1'b0;
			cmd_ex_r   <= 1'b0;
		end else begin
			ref_meta_r <= ref_due_r;
			ref_sync_r <= ref_sync_nxt;
			tgl_r      <= tgl_nxt;
			cmd_rd_r   <= cmd_rd_nxt;
			cmd_ex_r   <= cmd_ex_nxt;
		end
	end

	// Array has no reset
	always_ff @(negedge ck_x) begin
		if (we_hi)
			mem[addr_r].hi <= first_r;
		if (we_lo)
			mem[addr_r].lo <= dq_in;
	end

	// Pin drive: data and strobe float in reset and outside their phases
	always_comb begin
		dq_out                 = ck_x ? rd_r.hi : lo_r; // R3 R19
		dq_oe_b                = ~(link_arst_b && st_r == psram_strobe_pkg::S_RD); // R14 R16
		read_write_strobe_out  = 1'b0;
		read_write_strobe_oe_b = 1'b1;
		if (link_arst_b) begin // R2 R14
			case (st_r)
				psram_strobe_pkg::S_CMD: begin
					read_write_strobe_out  = ref_sync_r; // R12
					read_write_strobe_oe_b = 1'b0;
				end
				psram_strobe_pkg::S_LAT: begin
					read_write_strobe_out  = extra_r; // R12
					read_write_strobe_oe_b = 1'b0;
				end
				psram_strobe_pkg::S_RD: begin
					read_write_strobe_out  = CENTER_STROBE ? psc_x : ck_x; // R5 R10
					read_write_strobe_oe_b = 1'b0;
				end
				default: read_write_strobe_oe_b = 1'b1; // R8 R11
			endcase
		end
	end

	// Checks in the link domain
	sequence base_wait_s;
		(st_r == psram_strobe_pkg::S_LAT) [*4] ##1 (st_r != psram_strobe_pkg::S_LAT);
	endsequence
	sequence extra_wait_s;
		(st_r == psram_strobe_pkg::S_LAT) [*8] ##1 (st_r != psram_strobe_pkg::S_LAT);
	endsequence
	a_ca_takes_three: assert property (@(negedge ck_x) disable iff (!link_arst_b) // R1
		(st_r == psram_strobe_pkg::S_CMD && ca_cnt_r == 2'h2) |=> (st_r == psram_strobe_pkg::S_LAT))
		else $error("command phase did not end after three pairs");
	a_base_latency: assert property (@(negedge ck_x) disable iff (!link_arst_b) // R12
		(st_r == psram_strobe_pkg::S_CMD && ca_cnt_r == 2'h2 && !ref_sync_r) |=> base_wait_s)
		else $error("base latency length wrong");
	a_extra_latency: assert property (@(negedge ck_x) disable iff (!link_arst_b) // R12
		(st_r == psram_strobe_pkg::S_CMD && ca_cnt_r == 2'h2 && ref_sync_r) |=> extra_wait_s)
		else $error("extra latency length wrong");
	a_write_lines_in: assert property (@(negedge ck_x) disable iff (!link_arst_b) // R11 R16
		(st_r == psram_strobe_pkg::S_WR) |-> (dq_oe_b && read_write_strobe_oe_b))
		else $error("device drives lines during write data");
	a_read_lines_out: assert property (@(negedge ck_x) disable iff (!link_arst_b) // R16 R10
		(st_r == psram_strobe_pkg::S_RD) |-> (!dq_oe_b && !read_write_strobe_oe_b))
		else $error("read data phase not driven");
	a_read_next_word: assert property (@(negedge ck_x) disable iff (!link_arst_b) // R19
		(st_r == psram_strobe_pkg::S_RD) ##1 (st_r == psram_strobe_pkg::S_RD) |-> (addr_r == $past(addr_r) + 7'h01))
		else $error("read address did not advance per pair");
	a_mask_blocks: assert property (@(negedge ck_x) disable iff (!link_arst_b) // R20
		(st_r == psram_strobe_pkg::S_WR && read_write_strobe_in && fmask_r) |-> (!we_lo && !we_hi))
		else $error("masked write byte was stored");

	// Checks in the system domain
	a_reset_floats: assert property (@(posedge clock) disable iff (!rst_b) // R14
		(!hw_ok_r) |-> (dq_oe_b && read_write_strobe_oe_b))
		else $error("lines driven during hardware reset");
	a_reset_idles: assert property (@(posedge clock) disable iff (!rst_b) // R13
		(!hw_ok_r) |=> (count_r == psram_strobe_pkg::COUNT_RESET && !ref_due_r))
		else $error("hardware reset did not return to idle");
	a_refresh_wins: assert property (@(posedge clock) disable iff (!rst_b) // R12
		(hw_ok_r && ref_tick) |=> ref_due_r)
		else $error("refresh request lost");
	a_cmd_counted: assert property (@(posedge clock) disable iff (!rst_b) // R1
		(hw_ok_r && cmd_pulse) |=> (count_r == $past(count_r) + 16'h0001))
		else $error("accepted command not counted");

endmodule : psram_strobe_slave

// ==== tb/psram_master_model.sv ====
// Host-side link master model: frames, latency and write masks
module psram_master_model (
	output logic            cs_b,
	output logic            lk,
	output logic            lk_n,
	output logic            sk,
	output logic            sk_n,
	output logic      [7:0] dq,
	output logic            dqe,
	output logic            mk,
	output logic            mke,
	input  wire logic [7:0] dq_i,
	input  wire logic       st_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] wb [4];
	logic [1:0]  mb [4];
	logic [15:0] rb [4];
	logic [7:0]  plo;
	logic [7:0]  phi;
	logic        slo;
	logic        shi;
	logic        extra;
	int          st_bad;

	initial begin
		{cs_b, lk, lk_n, sk, sk_n} = 5'h15;
		{dq, dqe, mk, mke} = 11'h000;
		extra = 1'b0;
		st_bad = 0;
	end

	// One link cycle: rising byte, then falling byte
	task automatic cyc(input logic [7:0] h, input logic [7:0] l, input logic [1:0] m, input logic wr);
		dq = h;
		mk = m[1];
		{sk, sk_n} = 2'h1;
		#2 plo = dq_i;
		slo = st_i;
		#1 {lk, lk_n} = 2'h2;
		#3 {sk, sk_n} = {!wr, wr};
		dq = l;
		mk = m[0];
		#2 phi = dq_i;
		shi = st_i;
		#1 {lk, lk_n} = 2'h1;
		#3;
	endtask : cyc

	// Frame of n words; ab above zero cuts it after ab latency cycles
	task automatic frame(input logic rd, input logic [6:0] a, input int n, input int ab);
		psram_strobe_pkg::ca_t ca;
		int lat;
		ca = '0;
		ca.is_read = rd;
		ca.burst = 1'b1;
		ca.upper[3:0] = a[6:3];
		ca.lower = a[2:0];
		#3 cs_b = 1'b0;
		dqe = 1'b1;
		#3 extra = st_i;
		for (int i = 0; i < 3; i++) cyc(ca[47-16*i -: 8], ca[39-16*i -: 8], 2'h0, !rd);
		dqe = 1'b0;
		lat = (ab > 0) ? ab : (extra ? 8 : 4);
		for (int i = 0; i < lat; i++) cyc(8'h00, 8'h00, 2'h0, !rd);
		dqe = !rd && ab == 0;
		mke = dqe;
		for (int i = 0; i < n && ab == 0; i++) begin
			cyc(wb[i][15:8], wb[i][7:0], mb[i], !rd);
			rb[i][15:8] = phi;
			if (i > 0) rb[i-1][7:0] = plo;
			if (rd && (shi !== 1'b1 || (i > 0 && slo !== 1'b0))) st_bad++;
		end
		#2 if (n > 0) rb[n-1][7:0] = dq_i;
		{cs_b, dqe, mke} = 3'h4;
		#12;
	endtask : frame
endmodule : psram_master_model

// ==== tb/psram_bus_slave_strobe_tb.sv ====
// Self-checking bench for the strobe bus slave and its link master
module psram_bus_slave_strobe_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock;
	logic        rst_b;
	logic        hw_reset_b;
	wire logic   cs_b, lk, lk_n, sk, sk_n, dqe, mk, mke;
	wire logic [7:0] mdq;
	wire logic [7:0] dq_line;
	wire logic   st_line;
	logic [7:0]  dq_out;
	logic        dq_oe_b, st_out, st_oe_b, last_rd, refr, sel_exc;
	logic [15:0] count;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          cycles = 0;

	// Released lines show a changing pattern, never the old value
	assign dq_line = !dq_oe_b ? dq_out : (dqe ? mdq : 8'hA5 ^ {8{lk}});
	assign st_line = !st_oe_b ? st_out : (mke ? mk : lk);

	psram_strobe_slave psram_strobe_slave_inst (
		.clock(clock), .rst_b(rst_b), .hw_reset_b(hw_reset_b), .chip_select_b(cs_b),
		.bus_clock(lk), .clock_complement(lk_n), .shifted_clock(sk), .shifted_clock_complement(sk_n),
		.dq_in(dq_line), .dq_out(dq_out), .dq_oe_b(dq_oe_b), .read_write_strobe_in(st_line),
		.read_write_strobe_out(st_out), .read_write_strobe_oe_b(st_oe_b), .transaction_count(count),
		.last_was_read(last_rd), .refresh_pending(refr), .select_low_exceeded(sel_exc)
	);

	psram_master_model psram_master_model_inst (
		.cs_b(cs_b), .lk(lk), .lk_n(lk_n), .sk(sk), .sk_n(sk_n), .dq(mdq),
		.dqe(dqe), .mk(mk), .mke(mke), .dq_i(dq_line), .st_i(st_line)
	);

	initial begin
		clock = 1'b0;
		forever #20 clock = !clock;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			error_cnt++;
			results();
		end
	end

	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results

	task automatic check(input string w, input logic [15:0] e, input logic [15:0] s);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", w, e, s);
		end
	endtask : check

	task automatic clk(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : clk

	task automatic t_reset;
		check("count", 16'h0000, count);
		check("dq enable", 16'h0001, 16'(dq_oe_b));
		check("strobe enable", 16'h0001, 16'(st_oe_b));
		check("flags", 16'h0000, 16'({last_rd, refr, sel_exc}));
		$display("test reset done");
	endtask : t_reset

	task automatic t_abort;
		psram_master_model_inst.frame(1'b1, 7'h00, 0, 2);
		check("dq enable", 16'h0001, 16'(dq_oe_b));
		check("strobe enable", 16'h0001, 16'(st_oe_b));
		clk(4);
		check("count", 16'h0001, count);
		$display("test abort done");
	endtask : t_abort

	task automatic t_write_read;
		logic [15:0] exp [4] = '{16'h1000, 16'h10BB, 16'h1002, 16'h1003};
		for (int i = 0; i < 4; i++) begin
			psram_master_model_inst.wb[i] = 16'h1000 + 16'(i);
			psram_master_model_inst.mb[i] = 2'h0;
		end
		psram_master_model_inst.frame(1'b0, 7'h7E, 4, 0);
		psram_master_model_inst.wb[0] = 16'hAABB;
		psram_master_model_inst.mb[0] = 2'h2;
		psram_master_model_inst.wb[1] = 16'hCCDD;
		psram_master_model_inst.mb[1] = 2'h3;
		psram_master_model_inst.frame(1'b0, 7'h7F, 2, 0);
		psram_master_model_inst.frame(1'b1, 7'h7E, 4, 0);
		for (int i = 0; i < 4; i++) check("read word", exp[i], psram_master_model_inst.rb[i]);
		check("strobe faults", 16'h0000, 16'(psram_master_model_inst.st_bad));
		clk(4);
		check("count", 16'h0004, count);
		check("last read", 16'h0001, 16'(last_rd));
		$display("test write read done");
	endtask : t_write_read

	task automatic t_refresh;
		for (int k = 0; k < 120 && refr !== 1'b1; k++) clk(1);
		check("refresh pending", 16'h0001, 16'(refr));
		psram_master_model_inst.frame(1'b1, 7'h7E, 1, 0);
		psram_master_model_inst.frame(1'b1, 7'h7E, 1, 0);
		check("extra latency", 16'h0001, 16'(psram_master_model_inst.extra));
		check("late word", 16'h1000, psram_master_model_inst.rb[0]);
		clk(6);
		check("refresh cleared", 16'h0000, 16'(refr));
		$display("test refresh done");
	endtask : t_refresh

	task automatic t_select_limit;
		psram_master_model_inst.frame(1'b1, 7'h00, 0, 400);
		check("select limit", 16'h0001, 16'(sel_exc));
		clk(4);
		check("select limit", 16'h0000, 16'(sel_exc));
		$display("test select limit done");
	endtask : t_select_limit

	task automatic t_hw_reset;
		@(posedge clock) hw_reset_b <= 1'b0;
		clk(4);
		check("count", 16'h0000, count);
		check("enables", 16'h0003, 16'({dq_oe_b, st_oe_b}));
		check("refresh", 16'h0000, 16'(refr));
		@(posedge clock) hw_reset_b <= 1'b1;
		clk(5);
		psram_master_model_inst.frame(1'b1, 7'h00, 1, 0);
		clk(4);
		check("count", 16'h0001, count);
		$display("test hardware reset done");
	endtask : t_hw_reset

	initial begin
		rst_b = 1'b0;
		hw_reset_b = 1'b1;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		clk(5);
		t_reset();
		t_abort();
		t_write_read();
		t_refresh();
		t_select_limit();
		t_hw_reset();
		results();
	end
endmodule : psram_bus_slave_strobe_tb
